// file: isp_pkg.sv
// shared constants and types for the isa slave host port
package isp_pkg;
  localparam int unsigned ADDR_W       = 20;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned IO_ADDR_W    = 16;
  localparam int unsigned NUM_IRQ      = 4;
  localparam int unsigned NUM_DMA      = 3;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned RESET_STABLE_NS = 400;
  localparam int unsigned RESET_STABLE_CYC =
    (RESET_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // eight 16-bit ports across sixteen byte locations
  localparam int unsigned IO_PORTS     = 8;
  localparam int unsigned IO_SPAN_W    = 4;
  localparam int unsigned PORT_IDX_W   = 3;
  // 4-Kbyte memory window
  localparam int unsigned MEM_SPAN_W   = 12;
  // bus control and queue port indices, bus control field positions and reset value
  localparam logic [2:0] BUS_CTL_PORT  = 3'h7;
  localparam logic [2:0] ISQ_PORT      = 3'h6;
  localparam int unsigned MEM_EN_BIT   = 10;
  localparam int unsigned RDY_DIS_BIT  = 11;
  localparam logic [15:0] BUS_CTL_RST  = 16'h0000;
  // default base addresses (arbitrary)
  localparam logic [15:0] IO_BASE_DEF  = 16'h0300;
  localparam logic [19:0] MEM_BASE_DEF = 20'hd0000;
  localparam logic [19:0] ROM_BASE_DEF = 20'hc8000;
  localparam int unsigned ROM_SPAN_W   = 14;
  localparam int unsigned WAIT_CYC     = 2;
  typedef enum logic [1:0] {HOP_IDLE, HOP_ACT, HOP_HOLD} isp_hop_type;
endpackage : isp_pkg

// file: isp_bus_if.sv
// isa pin bundle joining host end and device end
`timescale 1ns/1ns
interface isp_bus_if;
  logic [19:0] sa;
  logic [15:0] sdHost;
  logic        sdHostOe;
  logic [15:0] sdDev;
  logic        sdDevOe;
  logic        resetHi;
  logic        aen;
  logic        memRdN;
  logic        memWrN;
  logic        ioRdN;
  logic        ioWrN;
  logic        refreshN;
  logic        sbheN;
  logic        extMemSelectN;
  logic [2:0]  dmaAckN;
  logic        testN;
  logic        memCs16Oe;
  logic        ioCs16Oe;
  logic        chanRdyOe;
  logic [3:0]  irqOut;
  logic [3:0]  irqOe;
  logic [2:0]  dmaReq;
  logic [2:0]  dmaReqOe;
  logic        bootRomSelectN;
  logic        serialMemDout;
  modport device (
    input  sa, sdHost, sdHostOe, resetHi, aen, memRdN, memWrN, ioRdN, ioWrN,
           refreshN, sbheN, extMemSelectN, dmaAckN, testN,
    output sdDev, sdDevOe, memCs16Oe, ioCs16Oe, chanRdyOe, irqOut, irqOe,
           dmaReq, dmaReqOe, bootRomSelectN, serialMemDout
  );
  modport host (
    output sa, sdHost, sdHostOe, resetHi, aen, memRdN, memWrN, ioRdN, ioWrN,
           refreshN, sbheN, extMemSelectN, dmaAckN, testN,
    input  sdDev, sdDevOe, memCs16Oe, ioCs16Oe, chanRdyOe, irqOut, irqOe,
           dmaReq, dmaReqOe, bootRomSelectN, serialMemDout
  );
endinterface : isp_bus_if

// file: isp_device.sv
// device end of the isa slave host port
`timescale 1ns/1ns
module isp_device #(
  parameter logic [15:0] IO_BASE  = isp_pkg::IO_BASE_DEF,
  parameter logic [19:0] MEM_BASE = isp_pkg::MEM_BASE_DEF,
  parameter logic [19:0] ROM_BASE = isp_pkg::ROM_BASE_DEF
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // isa pins
  isp_bus_if.device        bus,
  // internal user side
  input  wire logic        irqEvent,
  input  wire logic [1:0]  irqSelect,
  input  wire logic        dmaWant,
  input  wire logic [1:0]  dmaSelect,
  input  wire logic        serialMemData,
  input  wire logic        scanOut,
  input  wire logic        userReady,
  output logic             scanClk,
  output logic             dmaAckSeen,
  output logic             portResetHi
);
  // synchroniser stages for the strobe and control pins; sa, sdHost and sbheN are used unsynchronised
  localparam int unsigned SW = 9;
  logic [SW-1:0] syncA_q;
  logic [SW-1:0] syncB_q;
  wire  [SW-1:0] rawIn = {bus.resetHi, bus.aen, bus.memRdN, bus.memWrN, bus.ioRdN,
                          bus.ioWrN, bus.refreshN, bus.testN, bus.sbheN};
  always_ff @(posedge clk)
  begin
    syncA_q <= rawIn;
    syncB_q <= syncA_q;
  end
  wire rstS = syncB_q[8];
  wire aenS = syncB_q[7];
  wire memRdS = ~syncB_q[6];
  wire memWrS = ~syncB_q[5];
  wire ioRdS = ~syncB_q[4];
  wire ioWrS = ~syncB_q[3];
  wire refS = ~syncB_q[2];
  wire testS = ~syncB_q[1];
  logic [2:0] ackA_q;
  logic [2:0] ackB_q;
  logic       xselA_q;
  logic       xselB_q;
  always_ff @(posedge clk)
  begin
    ackA_q  <= ~bus.dmaAckN;
    ackB_q  <= ackA_q;
    xselA_q <= ~bus.extMemSelectN;
    xselB_q <= xselA_q;
  end

  logic [8:0] rstCnt_q;
  logic       portRst_q;
  always_ff @(posedge clk)
  begin
    if (!resetn || !rstS)
    begin
      rstCnt_q  <= 9'h000;
      portRst_q <= 1'b0;
    end
    else if (rstCnt_q < 9'(isp_pkg::RESET_STABLE_CYC))
      rstCnt_q <= rstCnt_q + 9'h001;
    else
      portRst_q <= 1'b1;
  end
  assign portResetHi = portRst_q;
  wire inReset = !resetn || portRst_q;

  wire ioHit  = (bus.sa[15:4] == IO_BASE[15:4]) && !aenS && !testS;
  wire memHit = (bus.sa[19:12] == MEM_BASE[19:12]) && xselB_q;
  wire romHit = bus.sa[19:14] == ROM_BASE[19:14];
  wire [2:0] portIdx = bus.sa[3:1];
  wire ioRd  = ioRdS && ioHit && !refS;
  wire ioWr  = ioWrS && ioHit && !refS;
  wire memRd = memRdS && !refS;
  wire memWr = memWrS && !refS;
  wire [2:0] ackV = refS ? 3'h0 : ackB_q;

  // i/o port registers
  logic [15:0] ports_q [isp_pkg::IO_PORTS];
  logic        ioWrD_q;
  logic        memWrD_q;
  wire [15:0]  bus_control_reg = ports_q[isp_pkg::BUS_CTL_PORT];
  wire         memEn  = bus_control_reg[isp_pkg::MEM_EN_BIT];
  wire         rdyDis = bus_control_reg[isp_pkg::RDY_DIS_BIT];
  wire         memMode = memEn && memHit;
  // write on strobe leading edge, high byte only with enable
  always_ff @(posedge clk)
  begin
    ioWrD_q  <= ioWr;
    memWrD_q <= memWr && memMode;
    if (inReset)
    begin
      for (int i = 0; i < isp_pkg::IO_PORTS; i++)
        ports_q[i] <= (i == int'(isp_pkg::BUS_CTL_PORT)) ? isp_pkg::BUS_CTL_RST : 16'h0000;
    end
    else if ((ioWr && !ioWrD_q) || (memWr && memMode && !memWrD_q))
    begin
      ports_q[portIdx][7:0] <= bus.sdHost[7:0];
      if (!bus.sbheN)
        ports_q[portIdx][15:8] <= bus.sdHost[15:8];
    end
  end

  // interrupt pending, line and queue read
  logic irqPend_q;
  logic irqLine_q;
  logic ioRdD_q;
  logic memRdD_q;
  wire  isqRead = ioRd && !ioRdD_q && portIdx == isp_pkg::ISQ_PORT;
  wire  rdStart = (ioRd && !ioRdD_q) || (memRd && memMode && !memRdD_q);
  always_ff @(posedge clk)
  begin
    ioRdD_q  <= ioRd;
    memRdD_q <= memRd && memMode;
    if (inReset)
    begin
      irqPend_q <= 1'b0;
      irqLine_q <= 1'b0;
    end
    else if (irqEvent)
    begin
      irqPend_q <= 1'b1;
      irqLine_q <= 1'b1;
    end
    else if (isqRead)
    begin
      irqPend_q <= 1'b0;
      // line drops only once the queue reads back empty
      if (!irqPend_q)
        irqLine_q <= 1'b0;
    end
  end

  logic [15:0] rdData_q;
  logic        rdOe_q;
  always_ff @(posedge clk)
  begin
    if (inReset)
    begin
      rdData_q <= 16'h0000;
      rdOe_q   <= 1'b0;
    end
    else
    begin
      rdOe_q <= ioRd || (memRd && memMode);
      // word held from the first strobe cycle, so a queue read keeps its value
      if (rdStart)
        rdData_q <= (portIdx == isp_pkg::ISQ_PORT) ? {15'h0000, irqPend_q} : ports_q[portIdx];
    end
  end
  assign bus.sdDev   = rdData_q;
  assign bus.sdDevOe = rdOe_q;

  assign bus.ioCs16Oe  = ioHit && !inReset;
  assign bus.memCs16Oe = memMode && !inReset;
  // ready stretch counted down over WAIT_CYC cycles with userReady high
  logic [1:0] waitCnt_q;
  always_ff @(posedge clk)
  begin
    if (inReset)
      waitCnt_q <= 2'h0;
    else if (rdStart && waitCnt_q == 2'h0 && !rdyDis)
      waitCnt_q <= 2'(isp_pkg::WAIT_CYC);
    else if (waitCnt_q != 2'h0 && userReady)
      waitCnt_q <= waitCnt_q - 2'h1;
  end
  assign bus.chanRdyOe = !rdyDis && waitCnt_q != 2'h0;

  genvar g;
  for (g = 0; g < isp_pkg::NUM_IRQ; g++)
  begin : gIrq
    assign bus.irqOe[g]  = !inReset && irqSelect == 2'(g);
    assign bus.irqOut[g] = irqLine_q;
  end
  for (g = 0; g < isp_pkg::NUM_DMA; g++)
  begin : gDma
    assign bus.dmaReqOe[g] = !inReset && dmaSelect == 2'(g);
    assign bus.dmaReq[g]   = dmaWant;
  end
  assign dmaAckSeen = (dmaSelect < 2'h3) ? ackV[dmaSelect] : 1'b0;

  // boot rom select on memory read
  assign bus.bootRomSelectN = !(romHit && memRd);
  assign scanClk           = testS && aenS;
  assign bus.serialMemDout = testS ? scanOut : serialMemData;
endmodule : isp_device

// file: isp_host.sv
// host end driving isa cycles from a plain command port
`timescale 1ns/1ns
module isp_host (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // isa pins
  isp_bus_if.host          bus,
  // command port
  input  wire logic [19:0] cmdAddr,
  input  wire logic [15:0] cmdData,
  input  wire logic        cmdIo,
  input  wire logic        cmdWrite,
  input  wire logic        cmdValid,
  output logic             cmdReady,
  output logic [15:0]      rspData,
  output logic             rspValid,
  // side pins
  input  wire logic [2:0]  dmaAckIn,
  input  wire logic        testIn
);
  isp_pkg::isp_hop_type st_q;
  logic [19:0] addr_q;
  logic [15:0] data_q;
  logic        io_q;
  logic        wr_q;
  logic        sbheDone_q;
  logic [2:0]  cnt_q;
  logic [15:0] rsp_q;
  logic        rspV_q;
  // ready sampled through two flops
  logic rdyA_q;
  logic rdyB_q;
  always_ff @(posedge clk)
  begin
    rdyA_q <= bus.chanRdyOe;
    rdyB_q <= rdyA_q;
  end
  wire act = st_q == isp_pkg::HOP_ACT;
  always_ff @(posedge clk)
  begin
    rspV_q <= 1'b0;
    if (!resetn)
    begin
      st_q       <= isp_pkg::HOP_IDLE;
      sbheDone_q <= 1'b0;
      cnt_q      <= 3'h0;
      addr_q     <= 20'h00000;
      data_q     <= 16'h0000;
      io_q       <= 1'b0;
      wr_q       <= 1'b0;
      rsp_q      <= 16'h0000;
    end
    else
    begin
      unique case (st_q)
        isp_pkg::HOP_IDLE:
          if (!sbheDone_q)
            sbheDone_q <= 1'b1;
          else if (cmdValid)
          begin
            st_q   <= isp_pkg::HOP_ACT;
            addr_q <= cmdAddr;
            data_q <= cmdData;
            io_q   <= cmdIo;
            wr_q   <= cmdWrite;
            cnt_q  <= 3'h0;
          end
        isp_pkg::HOP_ACT:
          if (cnt_q < 3'h6)
            cnt_q <= cnt_q + 3'h1;
          else if (!rdyB_q)
          begin
            rsp_q  <= bus.sdDev;
            rspV_q <= !wr_q;
            st_q   <= isp_pkg::HOP_HOLD;
          end
        isp_pkg::HOP_HOLD:
          st_q <= isp_pkg::HOP_IDLE;
      endcase
    end
  end
  assign cmdReady = st_q == isp_pkg::HOP_IDLE && sbheDone_q;
  assign rspData  = rsp_q;
  assign rspValid = rspV_q;
  // aen high only while a dma acknowledge is given
  assign bus.aen = |dmaAckIn;
  assign bus.sa = addr_q;
  assign bus.sdHost = data_q;
  assign bus.sdHostOe = act && wr_q;
  assign bus.ioRdN  = !(act && io_q && !wr_q);
  assign bus.ioWrN  = !(act && io_q && wr_q);
  assign bus.memRdN = !(act && !io_q && !wr_q);
  assign bus.memWrN = !(act && !io_q && wr_q);
  assign bus.sbheN  = !(act || (resetn && !sbheDone_q));
  assign bus.refreshN = 1'b1;
  assign bus.extMemSelectN = !(act && !io_q);
  assign bus.resetHi = !resetn;
  assign bus.dmaAckN = ~dmaAckIn;
  assign bus.testN = !testIn;
endmodule : isp_host

// file: isp_bus_props.sv
// pin-level properties of the isa slave host port
`timescale 1ns/1ns
module isp_bus_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // host-driven pins
  input wire logic [19:0] sa,
  input wire logic        aen,
  input wire logic        ioRdN,
  input wire logic        memRdN,
  input wire logic        sbheN,
  input wire logic [2:0]  dmaAckN,
  // device-driven pins
  input wire logic        sdDevOe,
  input wire logic        ioCs16Oe,
  input wire logic        memCs16Oe,
  input wire logic        chanRdyOe,
  input wire logic [3:0]  irqOe,
  input wire logic [2:0]  dmaReqOe,
  input wire logic        bootRomSelectN
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // address window hits
  wire ioHit  = sa[15:4] == isp_pkg::IO_BASE_DEF[15:4];
  wire memHit = sa[19:12] == isp_pkg::MEM_BASE_DEF[19:12];
  wire romHit = sa[19:14] == isp_pkg::ROM_BASE_DEF[19:14];
  sequence s_io_rd_start;
    $fell(ioRdN) && ioHit && !aen;
  endsequence
  sequence s_hbe_pulse;
    !sbheN ##1 sbheN;
  endsequence
  property p_io_sel;
    ioCs16Oe |-> ioHit || $past(ioHit) || $past(ioHit, 2);
  endproperty
  a_io_sel: assert property (p_io_sel) else $error("io select off range");
  property p_mem_sel;
    memCs16Oe |-> memHit || $past(memHit) || $past(memHit, 2);
  endproperty
  a_mem_sel: assert property (p_mem_sel) else $error("mem select off range");
  property p_rom_sel;
    !bootRomSelectN |-> romHit || $past(romHit) || $past(romHit, 2);
  endproperty
  a_rom_sel: assert property (p_rom_sel) else $error("rom select off range");
  property p_irq_one;
    $onehot0(irqOe);
  endproperty
  a_irq_one: assert property (p_irq_one) else $error("two irq lines driven");
  property p_dma_one;
    $onehot0(dmaReqOe);
  endproperty
  a_dma_one: assert property (p_dma_one) else $error("two dma lines driven");
  property p_no_drive;
    (ioRdN && memRdN && &dmaAckN)[*5] |-> !sdDevOe;
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("data driven idle");
  property p_aen_quiet;
    aen[*4] |-> !ioCs16Oe;
  endproperty
  a_aen_quiet: assert property (p_aen_quiet) else $error("io select under aen");
  property p_rdy;
    chanRdyOe |-> !ioRdN || !memRdN;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready pulled outside read");
  property p_rd_answer;
    s_io_rd_start |-> ##[1:6] sdDevOe;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("io read not answered");
  property p_hbe;
    $rose(resetn) |-> ##[0:2] s_hbe_pulse;
  endproperty
  a_hbe: assert property (p_hbe) else $error("no high enable pulse");
endmodule : isp_bus_props

// file: test_isp.sv
// self-checking bench joining host end and device end
`timescale 1ns/1ns
module test_isp;
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] data;
    logic        io;
    logic        wr;
    logic [15:0] exp;
  } isp_row_type;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        hostResetn = 1'b0;
  int          romLow = 0;
  logic [19:0] cmdAddr = 20'h00000;
  logic [15:0] cmdData = 16'h0000;
  logic        cmdIo = 1'b1;
  logic        cmdWrite = 1'b0;
  logic        cmdValid = 1'b0;
  logic        cmdReady, rspValid, scanClk, dmaAckSeen, portResetHi;
  logic [15:0] rspData, rd;
  logic [2:0]  dmaAckIn = 3'h0;
  logic        testIn = 1'b0;
  logic        irqEvent = 1'b0;
  logic        dmaWant = 1'b0;
  logic        scanOut = 1'b0;
  logic        serialMemData = 1'b0;
  int          mismatches = 0;
  int          cmpCount = 0;
  // address, data, io, write, expected read
  isp_row_type rows [16] = '{
    '{20'h00300, 16'h1234, 1'b1, 1'b1, 16'h0}, '{20'h00300, 16'h0, 1'b1, 1'b0, 16'h1234},
    '{20'h0030a, 16'ha5c3, 1'b1, 1'b1, 16'h0}, '{20'h0030a, 16'h0, 1'b1, 1'b0, 16'ha5c3},
    '{20'h10300, 16'h5a5a, 1'b1, 1'b1, 16'h0}, '{20'h00310, 16'hffff, 1'b1, 1'b1, 16'h0},
    '{20'h00300, 16'h0, 1'b1, 1'b0, 16'h5a5a}, '{20'h0030e, 16'h0400, 1'b1, 1'b1, 16'h0},
    '{20'hd0002, 16'hbeef, 1'b0, 1'b1, 16'h0}, '{20'h00302, 16'h0, 1'b1, 1'b0, 16'hbeef},
    '{20'hd0002, 16'h0, 1'b0, 1'b0, 16'hbeef}, '{20'h0030e, 16'h0000, 1'b1, 1'b1, 16'h0},
    '{20'hd0002, 16'h1111, 1'b0, 1'b1, 16'h0}, '{20'h00302, 16'h0, 1'b1, 1'b0, 16'hbeef},
    '{20'h0030e, 16'h0800, 1'b1, 1'b1, 16'h0}, '{20'h0030e, 16'h0, 1'b1, 1'b0, 16'h0800}
  };
  isp_bus_if bus ();
  // 250 MHz clock
  initial
  begin
    forever #2 clk = ~clk;
  end
  isp_device isp_device_i (.clk(clk), .resetn(resetn), .bus(bus), .irqEvent(irqEvent),
    .irqSelect(2'h2), .dmaWant(dmaWant), .dmaSelect(2'h1), .serialMemData(serialMemData),
    .scanOut(scanOut), .userReady(1'b1), .scanClk(scanClk), .dmaAckSeen(dmaAckSeen),
    .portResetHi(portResetHi));
  isp_host isp_host_i (.clk(clk), .resetn(hostResetn), .bus(bus), .cmdAddr(cmdAddr),
    .cmdData(cmdData), .cmdIo(cmdIo), .cmdWrite(cmdWrite), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .rspData(rspData), .rspValid(rspValid), .dmaAckIn(dmaAckIn),
    .testIn(testIn));
  isp_bus_props isp_bus_props_i (.clk(clk), .resetn(resetn && hostResetn), .sa(bus.sa),
    .aen(bus.aen),
    .ioRdN(bus.ioRdN), .memRdN(bus.memRdN), .sbheN(bus.sbheN), .dmaAckN(bus.dmaAckN),
    .sdDevOe(bus.sdDevOe), .ioCs16Oe(bus.ioCs16Oe), .memCs16Oe(bus.memCs16Oe),
    .chanRdyOe(bus.chanRdyOe), .irqOe(bus.irqOe), .dmaReqOe(bus.dmaReqOe),
    .bootRomSelectN(bus.bootRomSelectN));
  // counts cycles with the boot rom select low
  always @(negedge clk)
  begin
    if (bus.bootRomSelectN === 1'b0)
      romLow++;
  end
  // compare and count
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmpCount++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one host command, read data returned
  task automatic cmd(input isp_row_type w, output logic [15:0] r);
    int n;
    n = 0;
    r = 16'h0;
    @(posedge clk);
    cmdAddr  <= w.addr;
    cmdData  <= w.data;
    cmdIo    <= w.io;
    cmdWrite <= w.wr;
    cmdValid <= 1'b1;
    do @(negedge clk); while (cmdReady !== 1'b1 && ++n < 40);
    if (n >= 40)
    begin
      mismatches++;
      $display("ERROR cmdReady expected 1 seen 0");
    end
    @(posedge clk);
    cmdValid <= 1'b0;
    n = 0;
    if (!w.wr)
    begin
      do @(negedge clk); while (rspValid !== 1'b1 && ++n < 60);
      if (n >= 60)
      begin
        mismatches++;
        $display("ERROR rspValid expected 1 seen 0");
      end
      r = rspData;
    end
  endtask : cmd
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // watchdog
  initial
  begin
    #40000;
    mismatches++;
    wrap_up();
  end
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    resetn     <= 1'b1;
    hostResetn <= 1'b1;
    tick(4);
    chk("pin reset", 16'h0, {15'h0, portResetHi});
    foreach (rows[i])
    begin
      cmd(rows[i], rd);
      if (!rows[i].wr)
        chk("row read", rows[i].exp, rd);
    end
    // boot rom select only on its own window
    chk("no boot select", 16'h0, {15'h0, romLow != 0});
    cmd('{20'hc8002, 16'h0, 1'b0, 1'b0, 16'h0}, rd);
    chk("boot select", 16'h1, {15'h0, romLow != 0});
    // irq set, then queue drained
    @(posedge clk);
    irqEvent <= 1'b1;
    @(posedge clk);
    irqEvent <= 1'b0;
    tick(4);
    chk("irq line", 16'h1, {15'h0, bus.irqOut[2]});
    chk("irq enables", 16'h4, {12'h0, bus.irqOe});
    cmd('{20'h0030c, 16'h0, 1'b1, 1'b0, 16'h0}, rd);
    chk("queue pending", 16'h1, {15'h0, rd[0]});
    chk("irq held", 16'h1, {15'h0, bus.irqOut[2]});
    cmd('{20'h0030c, 16'h0, 1'b1, 1'b0, 16'h0}, rd);
    chk("queue empty", 16'h0, rd);
    tick(4);
    chk("irq low", 16'h0, {15'h0, bus.irqOut[2]});
    // dma request and acknowledge
    @(posedge clk);
    dmaWant <= 1'b1;
    tick(4);
    chk("dma enables", 16'h2, {13'h0, bus.dmaReqOe});
    chk("dma request", 16'h1, {15'h0, bus.dmaReq[1]});
    @(posedge clk);
    dmaAckIn <= 3'h2;
    tick(6);
    chk("ack seen", 16'h1, {15'h0, dmaAckSeen});
    chk("aen in dma", 16'h1, {15'h0, bus.aen});
    chk("io select in dma", 16'h0, {15'h0, bus.ioCs16Oe});
    cmd('{20'h00300, 16'h1357, 1'b1, 1'b1, 16'h0}, rd);
    // let the ignored write finish before aen drops
    tick(12);
    @(posedge clk);
    dmaAckIn <= 3'h0;
    dmaWant  <= 1'b0;
    tick(4);
    cmd('{20'h00300, 16'h0, 1'b1, 1'b0, 16'h0}, rd);
    chk("write under aen", 16'h5a5a, rd);
    // scan output takes over serial dout
    @(posedge clk);
    testIn   <= 1'b1;
    scanOut  <= 1'b1;
    dmaAckIn <= 3'h1;
    tick(4);
    chk("scan out", 16'h1, {15'h0, bus.serialMemDout});
    chk("scan clock", 16'h1, {15'h0, scanClk});
    @(posedge clk);
    testIn   <= 1'b0;
    dmaAckIn <= 3'h0;
    tick(4);
    chk("serial dout", 16'h0, {15'h0, bus.serialMemDout});
    chk("scan clock off", 16'h0, {15'h0, scanClk});
    // pin reset honoured only after it has stood long enough
    @(posedge clk);
    hostResetn <= 1'b0;
    tick(90);
    chk("pin reset early", 16'h0, {15'h0, portResetHi});
    tick(30);
    chk("pin reset late", 16'h1, {15'h0, portResetHi});
    @(posedge clk);
    hostResetn <= 1'b1;
    tick(4);
    cmd('{20'h00300, 16'h0, 1'b1, 1'b0, 16'h0}, rd);
    chk("port after reset", 16'h0, rd);
    wrap_up();
  end
endmodule : test_isp
